// *** pdtx_divider.sv ***
// bit-time enable divider
module pdtx_divider
    import pdtx_pkg::*;
#(
    parameter int unsigned DIV = BIT_CYCLES
)
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // control
    input wire logic i_run,
    output logic o_tick
);
    localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_r;

    // restarts while idle so the first bit of a frame is full length
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
            cnt_r <= '0;
        else if (!i_run || cnt_r == LAST)
            cnt_r <= '0;
        else
            cnt_r <= cnt_r + CW'(1);
    end

    assign o_tick = i_run && (cnt_r == LAST);
endmodule

// *** pdtx_partner.sv ***
// queue feeder and collision source on the far side of the line
module pdtx_partner
    import pdtx_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // scenario control
    input wire logic i_load,
    input wire logic [3:0] i_count,
    input wire logic [3:0] i_base,
    input wire pdtx_kind_type i_coll_kind,
    // block side
    input wire logic i_q_pop,
    input wire pdtx_sym_type i_sym,
    output logic o_q_valid,
    output logic [3:0] o_q_nibble,
    output logic o_collision
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] left_r;
    logic [3:0] nib_r;
    logic hit_r;
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            left_r <= 4'h0;
            nib_r <= 4'h0;
            hit_r <= 1'b0;
        end
        else if (i_load)
        begin
            left_r <= i_count;
            nib_r <= i_base;
            hit_r <= 1'b0;
        end
        else
        begin
            if (i_q_pop && left_r != 4'h0)
            begin
                left_r <= left_r - 4'h1;
                nib_r <= nib_r + 4'h1;
            end
            if (o_collision)
                hit_r <= 1'b1;
        end
    end
    assign o_q_valid = left_r != 4'h0;
    // an empty queue shows no stale head
    assign o_q_nibble = o_q_valid ? nib_r : ~nib_r;
    assign o_collision = !hit_r && i_coll_kind != SK_NONE
        && i_sym.kind == i_coll_kind;
endmodule

// *** pdtx_pkg.sv ***
// constants, types and register map of the transmit launch and preamble block
// Operation
// - abort in packet: finish nibble, send end
// - abort in preamble: finish current preamble bit
// - launch bit one starts queued packet transmission
// - hard request in auto mode sends hard reset
// - cable request in auto mode sends cable reset; the code sends hard reset instead when hard is also requested
// - hardware clears launch bit; block reset clears
// - writing zero to launch bit does nothing
// - collision aborts, sets aborted flag, interrupts
// - seven-bit preamble count, default sixty-four
// - preamble always starts with zero bit
package pdtx_pkg;
    // timing
    localparam int unsigned CLK_FREQ_KHZ = 10000;
    localparam int unsigned BIT_RATE_KBPS = 300;
    localparam int unsigned BIT_CYCLES = CLK_FREQ_KHZ / BIT_RATE_KBPS;
    localparam int unsigned SYM_BITS = 5;
    localparam int unsigned SOP_SYMS = 4;
    localparam int unsigned RST_SYMS = 4;

    // register indices, byte address is four times the index
    localparam int unsigned IDX_CTL_A = 32'h0000_1A00;
    localparam int unsigned IDX_LAUNCH = 32'h0000_1A05;
    localparam int unsigned IDX_PREAMBLE = 32'h0000_1A06;
    localparam int unsigned IDX_IRQ_STAT = 32'h0000_1A10;
    localparam int unsigned IDX_IRQ_MASK = 32'h0000_1A11;
    localparam logic [15:0] ADDR_CTL_A = 16'(IDX_CTL_A * 4);
    localparam logic [15:0] ADDR_LAUNCH = 16'(IDX_LAUNCH * 4);
    localparam logic [15:0] ADDR_PREAMBLE = 16'(IDX_PREAMBLE * 4);
    localparam logic [15:0] ADDR_IRQ_STAT = 16'(IDX_IRQ_STAT * 4);
    localparam logic [15:0] ADDR_IRQ_MASK = 16'(IDX_IRQ_MASK * 4);

    // field positions
    localparam int unsigned BIT_MANUAL = 0;
    localparam int unsigned BIT_GO = 0;
    localparam int unsigned BIT_ABORT = 1;
    localparam int unsigned BIT_HARD = 2;
    localparam int unsigned BIT_CABLE = 3;
    localparam int unsigned IRQ_EOP = 0;
    localparam int unsigned IRQ_ABORTED = 1;
    localparam int unsigned IRQ_RST_SENT = 2;
    localparam int unsigned IRQ_W = 3;

    // reset values
    localparam logic [6:0] PREAMBLE_RST = 7'h40;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h0,
        ST_PRE = 3'h1,
        ST_SOP = 3'h3,
        ST_DATA = 3'h2,
        ST_EOP = 3'h6,
        ST_RST = 3'h7
    } pdtx_state_type;

    typedef enum logic [2:0]
    {
        SK_NONE = 3'h0,
        SK_PRE = 3'h1,
        SK_SOP = 3'h2,
        SK_DATA = 3'h3,
        SK_EOP = 3'h4,
        SK_HRST = 3'h5,
        SK_CRST = 3'h6
    } pdtx_kind_type;

    typedef struct packed
    {
        logic valid;
        pdtx_kind_type kind;
        logic [3:0] nibble;
        logic line_bit;
    } pdtx_sym_type;
endpackage

// *** pdtx_preamble.sv ***
// preamble bit counter and pattern source
module pdtx_preamble
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // control
    input wire logic i_clear,
    input wire logic i_tick,
    input wire logic [6:0] i_len,
    // pattern
    output logic o_bit,
    output logic o_last
);
    logic [6:0] cnt_r;

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
            cnt_r <= 7'h00;
        else if (i_clear)
            cnt_r <= 7'h00;
        else if (i_tick)
            cnt_r <= cnt_r + 7'h01;
    end

    assign o_bit = cnt_r[0];
    // length zero is not checked and wraps around
    assign o_last = (cnt_r == i_len - 7'h01);
endmodule

// *** pdtx_top.sv ***
// transmit launch, abort, reset signalling and preamble control
module pdtx_top
    import pdtx_pkg::*;
#(
    parameter int unsigned BIT_DIV = BIT_CYCLES
)
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_pd_block_reset,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [15:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    // transmit queue
    input wire logic i_q_valid,
    input wire logic [3:0] i_q_nibble,
    output logic o_q_pop,
    // line side
    input wire logic i_collision,
    output pdtx_sym_type o_sym,
    output logic o_tx_active,
    // interrupt
    output logic o_irq
);
    pdtx_state_type state_r;
    logic go_r, hard_req_r, cable_req_r, hard_sel_r, cable_sel_r;
    logic abort_r, manual_r, pready_r, pslverr_r, q_pop_r, irq_r;
    logic [6:0] pre_len_r;
    logic [IRQ_W-1:0] irq_stat_r, irq_mask_r;
    logic [2:0] sym_cnt_r;
    logic [1:0] grp_cnt_r;
    logic [3:0] nibble_r;
    logic [31:0] prdata_r;
    pdtx_sym_type sym_r;
    logic bit_tick, pre_bit, pre_last, busy, sym_end, grp_last, start;
    logic take_nibble, fin_pre, fin_eop, fin_rst, finish;
    logic wr_en, rd_en, mapped, sw_abort;
    logic [IRQ_W-1:0] irq_set, irq_clr;
    assign busy = (state_r != ST_IDLE);
    pdtx_divider #(
        .DIV(BIT_DIV)
    ) u_div (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_run(busy),
        .o_tick(bit_tick)
    );
    pdtx_preamble u_pre (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_clear(state_r != ST_PRE),
        .i_tick(bit_tick),
        .i_len(pre_len_r),
        .o_bit(pre_bit),
        .o_last(pre_last)
    );
    // apb decode; the access completes on the edge where pready is high
    assign wr_en = i_psel && i_penable && pready_r && i_pwrite;
    assign rd_en = i_psel && !i_penable && !i_pwrite;
    assign mapped = (i_paddr == ADDR_CTL_A) || (i_paddr == ADDR_LAUNCH)
        || (i_paddr == ADDR_PREAMBLE) || (i_paddr == ADDR_IRQ_STAT)
        || (i_paddr == ADDR_IRQ_MASK);
    assign sw_abort = wr_en && (i_paddr == ADDR_LAUNCH)
        && i_pwdata[BIT_ABORT];
    assign sym_end = bit_tick && (sym_cnt_r == 3'(SYM_BITS - 1));
    assign grp_last = (state_r == ST_SOP) ? (grp_cnt_r == 2'(SOP_SYMS - 1))
        : (grp_cnt_r == 2'(RST_SYMS - 1));
    assign start = go_r && !busy && !i_pd_block_reset;
    assign take_nibble = sym_end && !abort_r && i_q_valid
        && (((state_r == ST_SOP) && grp_last) || (state_r == ST_DATA));
    assign fin_pre = (state_r == ST_PRE) && bit_tick && abort_r;
    assign fin_eop = (state_r == ST_EOP) && sym_end;
    assign fin_rst = (state_r == ST_RST) && sym_end && (grp_last || abort_r);
    assign finish = fin_pre || fin_eop || fin_rst;
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
            abort_r <= 1'b0;
        else if (!busy || i_pd_block_reset)
            abort_r <= 1'b0;
        else if (sw_abort || i_collision)
            abort_r <= 1'b1;
    end

    // frame sequencer
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
            state_r <= ST_IDLE;
        else if (i_pd_block_reset)
            state_r <= ST_IDLE;
        else
        begin
            case (state_r)
                ST_IDLE:
                    if (start)
                        state_r <= ST_PRE;
                ST_PRE:
                    if (bit_tick)
                    begin
                        if (abort_r)
                            state_r <= ST_IDLE;
                        else if (pre_last)
                            state_r <= (hard_sel_r || cable_sel_r)
                                ? ST_RST : ST_SOP;
                    end
                ST_SOP:
                    if (sym_end && (abort_r || grp_last))
                        state_r <= take_nibble ? ST_DATA : ST_EOP;
                ST_DATA:
                    if (sym_end && !take_nibble)
                        state_r <= ST_EOP;
                ST_EOP:
                    if (sym_end)
                        state_r <= ST_IDLE;
                ST_RST:
                    if (fin_rst)
                        state_r <= ST_IDLE;
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // bit and symbol counters
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            sym_cnt_r <= 3'h0;
            grp_cnt_r <= 2'h0;
        end
        else if (state_r == ST_IDLE || state_r == ST_PRE)
        begin
            sym_cnt_r <= 3'h0;
            grp_cnt_r <= 2'h0;
        end
        else if (sym_end)
        begin
            sym_cnt_r <= 3'h0;
            grp_cnt_r <= grp_cnt_r + 2'h1;
        end
        else if (bit_tick)
            sym_cnt_r <= sym_cnt_r + 3'h1;
    end

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            hard_sel_r <= 1'b0;
            cable_sel_r <= 1'b0;
        end
        else if (start)
        begin
            hard_sel_r <= hard_req_r && !manual_r;
            cable_sel_r <= cable_req_r && !hard_req_r && !manual_r;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
            go_r <= 1'b0;
        else if (i_pd_block_reset || finish)
            go_r <= 1'b0;
        else if (wr_en && (i_paddr == ADDR_LAUNCH) && i_pwdata[BIT_GO])
            go_r <= 1'b1;
    end

    // reset requests also drop when the transfer completes
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            hard_req_r <= 1'b0;
            cable_req_r <= 1'b0;
        end
        else if (i_pd_block_reset || finish)
        begin
            hard_req_r <= 1'b0;
            cable_req_r <= 1'b0;
        end
        else if (wr_en && (i_paddr == ADDR_LAUNCH))
        begin
            hard_req_r <= i_pwdata[BIT_HARD];
            cable_req_r <= i_pwdata[BIT_CABLE];
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            pre_len_r <= PREAMBLE_RST;
            manual_r <= 1'b0;
            irq_mask_r <= IRQ_MASK_RST;
        end
        else if (wr_en)
        begin
            if (i_paddr == ADDR_PREAMBLE)
                pre_len_r <= i_pwdata[6:0];
            if (i_paddr == ADDR_CTL_A)
                manual_r <= i_pwdata[BIT_MANUAL];
            if (i_paddr == ADDR_IRQ_MASK)
                irq_mask_r <= i_pwdata[IRQ_W-1:0];
        end
    end

    // sticky events; a new event wins over a same-cycle clear
    assign irq_set[IRQ_EOP] = fin_eop;
    assign irq_set[IRQ_ABORTED] = busy && (i_collision || sw_abort);
    assign irq_set[IRQ_RST_SENT] = fin_rst;
    assign irq_clr = (wr_en && (i_paddr == ADDR_IRQ_STAT))
        ? i_pwdata[IRQ_W-1:0] : '0;

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
            irq_stat_r <= '0;
        else
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
    end

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
            irq_r <= 1'b0;
        else
            irq_r <= |(irq_stat_r & irq_mask_r);
    end

    // queue drain, one nibble per symbol
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            q_pop_r <= 1'b0;
            nibble_r <= 4'h0;
        end
        else
        begin
            q_pop_r <= take_nibble;
            if (take_nibble)
                nibble_r <= i_q_nibble;
        end
    end

    // line symbol, one cycle behind the sequencer
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
            sym_r <= '0;
        else
        begin
            sym_r.valid <= busy;
            sym_r.nibble <= (state_r == ST_DATA) ? nibble_r : 4'h0;
            sym_r.line_bit <= (state_r == ST_PRE) && pre_bit;
            case (state_r)
                ST_PRE:
                    sym_r.kind <= SK_PRE;
                ST_SOP:
                    sym_r.kind <= SK_SOP;
                ST_DATA:
                    sym_r.kind <= SK_DATA;
                ST_EOP:
                    sym_r.kind <= SK_EOP;
                ST_RST:
                    sym_r.kind <= hard_sel_r ? SK_HRST : SK_CRST;
                default:
                    sym_r.kind <= SK_NONE;
            endcase
        end
    end

    // apb answer: no wait states, read data captured in setup
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r <= i_psel && !i_penable;
            pslverr_r <= i_psel && !i_penable && !mapped;
            if (rd_en)
            begin
                prdata_r <= 32'h0000_0000;
                case (i_paddr)
                    ADDR_CTL_A:
                        prdata_r[BIT_MANUAL] <= manual_r;
                    ADDR_LAUNCH:
                    begin
                        prdata_r[BIT_GO] <= go_r;
                        prdata_r[BIT_HARD] <= hard_req_r;
                        prdata_r[BIT_CABLE] <= cable_req_r;
                    end
                    ADDR_PREAMBLE:
                        prdata_r[6:0] <= pre_len_r;
                    ADDR_IRQ_STAT:
                        prdata_r[IRQ_W-1:0] <= irq_stat_r;
                    ADDR_IRQ_MASK:
                        prdata_r[IRQ_W-1:0] <= irq_mask_r;
                    default:
                        prdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign o_pready = pready_r;
    assign o_prdata = prdata_r;
    assign o_pslverr = pslverr_r;
    assign o_q_pop = q_pop_r;
    assign o_sym = sym_r;
    assign o_tx_active = sym_r.valid;
    assign o_irq = irq_r;
endmodule

// *** pdtx_top_props.sv ***
// concurrent checks on the ports of the transmit launch block
module pdtx_top_props
    import pdtx_pkg::*;
#(
    parameter int unsigned BIT_DIV = BIT_CYCLES
)
(
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_pd_block_reset,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [15:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_q_pop,
    input wire logic o_tx_active,
    input wire pdtx_sym_type o_sym
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned SYMC = SYM_BITS * BIT_DIV;
    pdtx_kind_type prev_r;
    logic bit_r;
    logic blk_r;
    int unsigned run_r;
    int unsigned bit_run_r;
    wire logic chg = o_sym.kind != prev_r;
    wire logic bchg = chg || (o_sym.line_bit != bit_r);
    // run lengths of each kind and of each preamble bit
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            prev_r <= SK_NONE;
            bit_r <= 1'b0;
            blk_r <= 1'b0;
            run_r <= 0;
            bit_run_r <= 0;
        end
        else
        begin
            prev_r <= o_sym.kind;
            bit_r <= o_sym.line_bit;
            blk_r <= i_pd_block_reset;
            run_r <= chg ? 1 : run_r + 1;
            bit_run_r <= bchg ? 1 : bit_run_r + 1;
        end
    end
    default clocking @(posedge i_clock); endclocking
    // block reset cuts symbols short, so it is excluded for its lag too
    default disable iff (!i_rst_b || i_pd_block_reset || blk_r);
    sequence s_setup;
        i_psel && !i_penable;
    endsequence
    sequence s_go;
        s_setup ##1 i_penable && o_pready && i_pwrite
            && i_paddr == ADDR_LAUNCH && i_pwdata[BIT_GO] && !o_tx_active;
    endsequence
    a_apb_answer: assert property (s_setup |=> o_pready && i_penable)
        else $error("no answer after setup");
    a_err_ready: assert property (o_pslverr |-> o_pready)
        else $error("error without ready");
    a_launch_start: assert property (s_go |-> ##[2:3] (o_sym.valid
        && o_sym.kind == SK_PRE && !o_sym.line_bit))
        else $error("launch did not start preamble with zero");
    a_active_valid: assert property (o_tx_active == (o_sym.kind != SK_NONE))
        else $error("active differs from valid");
    a_pre_bit_time: assert property (o_sym.kind == SK_PRE
        && prev_r == SK_PRE |-> (o_sym.line_bit != bit_r)
        == (bit_run_r == BIT_DIV))
        else $error("preamble bit not alternating per bit time");
    a_pre_whole_bit: assert property (chg && prev_r == SK_PRE
        |-> bit_run_r == BIT_DIV)
        else $error("preamble ended inside a bit");
    a_sym_whole: assert property (chg && prev_r inside {SK_SOP,
        SK_DATA, SK_EOP, SK_HRST, SK_CRST} |-> run_r % SYMC == 0)
        else $error("symbol cut short");
    a_data_to_eop: assert property (chg && prev_r == SK_DATA
        |-> o_sym.kind == SK_EOP)
        else $error("data not closed by end symbol");
    a_eop_one_sym: assert property (chg && prev_r == SK_EOP
        |-> run_r == SYMC && o_sym.kind == SK_NONE)
        else $error("end symbol length wrong");
    a_bit_idle_low: assert property (o_sym.kind != SK_PRE
        |-> !o_sym.line_bit)
        else $error("line bit set outside preamble");
    a_pop_pulse: assert property (o_q_pop |=> !o_q_pop)
        else $error("pop longer than one cycle");
endmodule

bind pdtx_top pdtx_top_props #(.BIT_DIV(BIT_DIV)) u_props (.*);

// *** tb_pdtx_top.sv ***
// self-checking bench for the transmit launch block
module tb_pdtx_top
    import pdtx_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DIV = 4;
    logic i_clock = 0, i_rst_b = 0, blk = 0, psel = 0, pen = 0, pw = 0;
    logic [15:0] pa = 0;
    logic [31:0] pd = 0;
    logic load = 0, lastb = 0;
    logic [3:0] cnt = 0, base = 0, qn;
    pdtx_kind_type ck = SK_NONE, lk = SK_NONE, kq[$];
    logic pready, pslverr, qv, qpop, coll, act, irq;
    logic [31:0] prdata;
    pdtx_sym_type sym;
    logic [32:0] rq[$];
    logic [3:0] nq[$];
    int err_count = 0, cmp_count = 0, run = 0, pre_exp = 0, n;
    pdtx_top #(.BIT_DIV(DIV)) dut_u (.i_clock(i_clock), .i_rst_b(i_rst_b),
        .i_pd_block_reset(blk), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pw), .i_paddr(pa), .i_pwdata(pd), .o_pready(pready),
        .o_prdata(prdata), .o_pslverr(pslverr), .i_q_valid(qv),
        .i_q_nibble(qn), .o_q_pop(qpop), .i_collision(coll), .o_sym(sym),
        .o_tx_active(act), .o_irq(irq));
    pdtx_partner peer_u (.i_clock(i_clock), .i_rst_b(i_rst_b),
        .i_load(load), .i_count(cnt), .i_base(base), .i_coll_kind(ck),
        .i_q_pop(qpop), .i_sym(sym), .o_q_valid(qv), .o_q_nibble(qn),
        .o_collision(coll));
    initial
    begin
        forever #50 i_clock = ~i_clock;
    end
    task automatic cmp(input logic [32:0] g, input logic [32:0] e);
        cmp_count++;
        if (g !== e)
        begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [15:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pw <= w;
        pa <= a;
        pd <= d;
        @(posedge i_clock);
        pen <= 1'b1;
        do
        begin
            @(posedge i_clock);
        end
        while (pready !== 1'b1);
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge i_clock);
    endtask
    task automatic rd(input logic [15:0] a, input logic [32:0] e);
        rq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic start(input int len, input pdtx_kind_type c,
        input int cn, input int nd);
        int b;
        b = $urandom % 16;
        // callers never pass a zero length
        apb(1'b1, ADDR_PREAMBLE, 32'(len));
        cnt <= 4'(cn);
        base <= 4'(b);
        ck <= c;
        load <= 1'b1;
        @(posedge i_clock);
        load <= 1'b0;
        for (int k = 0; k < nd; k++)
            nq.push_back(4'(b + k));
        pre_exp = len;
    endtask
    task automatic done();
        repeat (3) @(posedge i_clock);
        // a hang here is ended by the watchdog
        while (act !== 1'b0)
            @(posedge i_clock);
        repeat (3) @(posedge i_clock);
    endtask
    always @(posedge i_clock)
        if (psel && pen && pready === 1'b1 && !pw)
            cmp({pslverr, prdata}, rq.size() ? rq.pop_front() : 'x);
    always @(negedge i_clock)
    begin
        if (sym.kind !== lk)
        begin
            if (lk == SK_PRE && pre_exp != 0)
            begin
                cmp(33'(run), 33'(pre_exp * DIV));
                cmp(33'(lastb), 33'(pre_exp % 2 == 0));
            end
            cmp(33'(sym.kind), kq.size() ? 33'(kq.pop_front()) : 'x);
            run = 0;
        end
        if (sym.kind == SK_DATA && run % (SYM_BITS * DIV) == 0)
            cmp(33'(sym.nibble), nq.size() ? 33'(nq.pop_front()) : 'x);
        lastb = sym.line_bit;
        lk = sym.kind;
        run++;
    end
    initial
    begin
        repeat (30000) @(posedge i_clock);
        err_count++;
        stop_test();
    end
    initial
    begin
        void'($urandom(9));
        repeat (6) @(posedge i_clock);
        i_rst_b <= 1'b1;
        @(posedge i_clock);
        rd(ADDR_PREAMBLE, 33'h40);
        rd(ADDR_LAUNCH, 33'h0);
        rd(ADDR_IRQ_MASK, 33'h0);
        rd(16'h0100, 33'h1_0000_0000);
        apb(1'b1, ADDR_PREAMBLE, 32'hFF);
        rd(ADDR_PREAMBLE, 33'h7F);
        $display("test registers done");
        for (int i = 0; i < 2; i++)
        begin
            n = 1 + $urandom % 4;
            kq = {kq, SK_PRE, SK_SOP, SK_DATA, SK_EOP, SK_NONE};
            start(3 + i, SK_NONE, n, n);
            apb(1'b1, ADDR_LAUNCH, 32'h1);
            apb(1'b1, ADDR_LAUNCH, 32'h0);
            rd(ADDR_LAUNCH, 33'h1);
            done();
            rd(ADDR_LAUNCH, 33'h0);
            // completion taken from status, not launch
            rd(ADDR_IRQ_STAT, 33'h1);
            cmp(33'(irq), 33'(i != 0));
            apb(1'b1, ADDR_IRQ_MASK, 32'h7);
            apb(1'b1, ADDR_IRQ_STAT, 32'h7);
            repeat (2) @(posedge i_clock);
            cmp(33'(irq), 33'h0);
        end
        $display("test packets done");
        kq = {kq, SK_PRE, SK_NONE};
        start(8, SK_NONE, 2, 0);
        pre_exp = 0;
        apb(1'b1, ADDR_LAUNCH, 32'h1);
        repeat (5) @(posedge i_clock);
        apb(1'b1, ADDR_LAUNCH, 32'h2);
        done();
        rd(ADDR_IRQ_STAT, 33'h2);
        apb(1'b1, ADDR_IRQ_STAT, 32'h7);
        $display("test abort done");
        kq = {kq, SK_PRE, SK_SOP, SK_DATA, SK_EOP, SK_NONE};
        start(4, SK_DATA, 3, 1);
        apb(1'b1, ADDR_LAUNCH, 32'h1);
        done();
        cmp(33'(irq), 33'h1);
        rd(ADDR_IRQ_STAT, 33'h3);
        apb(1'b1, ADDR_IRQ_STAT, 32'h7);
        $display("test collision done");
        for (int k = 0; k < 3; k++)
        begin
            apb(1'b1, ADDR_CTL_A, 32'(k == 2));
            if (k < 2)
                kq = {kq, SK_PRE, k ? SK_CRST : SK_HRST, SK_NONE};
            else
                kq = {kq, SK_PRE, SK_SOP, SK_DATA, SK_EOP, SK_NONE};
            start(4, SK_NONE, 1, k / 2);
            // both requests at once in auto mode (k 0): hard reset wins
            apb(1'b1, ADDR_LAUNCH, k == 1 ? 32'h9 : 32'hD);
            done();
            rd(ADDR_IRQ_STAT, k < 2 ? 33'h4 : 33'h1);
            apb(1'b1, ADDR_IRQ_STAT, 32'h7);
        end
        apb(1'b1, ADDR_CTL_A, 32'h0);
        $display("test reset signalling done");
        kq = {kq, SK_PRE, SK_NONE};
        start(8, SK_NONE, 1, 0);
        pre_exp = 0;
        apb(1'b1, ADDR_LAUNCH, 32'h1);
        repeat (6) @(posedge i_clock);
        blk <= 1'b1;
        repeat (3) @(posedge i_clock);
        blk <= 1'b0;
        done();
        rd(ADDR_LAUNCH, 33'h0);
        $display("test block reset done");
        stop_test();
    end
endmodule
